// >>> hw/vgar_regs.sv
// Purpose: standard display register file reached by host byte I/O cycles
// Assumes: IO_WR_IN and IO_RD_IN are one-cycle strobes, one per access
// Notes: read data is registered and valid the cycle after the strobe
// Function
// - crt index/data and status 1 sit at mono or color base per output bit 0
// - output bits 3:2 pick 25 MHz, 28 MHz, auxiliary or 45 MHz pixel clock
// - output bits 6 and 7 set hsync and vsync polarity, 1 is negative
// - status 0 bit 7 shows pending interrupt, bit 4 selected switch sense
// - status 1 bit 0 low in display, bit 3 retrace, bits 5:4 muxed palette
// - host writes sequencer index, data port then reaches the indexed register
// - sequencer reset bits 0 and 1 hold async and sync resets when 0
// - clocking mode selects 9/8 dots, halving, quarter load and screen off
// - map mask bits enable host writes to planes 0 to 3
// - memory mode picks 64K/256K, odd/even addressing and chain-4
// - vertical values are 10 bits built from overflow and max scan line
// - retrace end bit 4 written 0 clears interrupt, bit 5 enables it
// - retrace end bit 6 picks 3 or 5 refreshes, bit 7 protects crt 00-07
// - mode control bit 7 low holds retrace counters in reset
// - mode control wraps at address bit 13 or 15, row scan substitution
// - data rotate gives rotate count and latch logic function
// - graphics mode bits 1:0 select the write mode
// - graphics mode bit 3 picks map-select read or color-compare read
// - graphics misc bits 3:2 choose the host memory window
// - attribute index bit 5 hands palette to host or display pipeline
`timescale 1ns/1ps

module vgar_regs
	import vgar_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	// host i/o cycle
	input wire logic [15:0] IO_ADDR_IN,
	input wire logic IO_WR_IN,
	input wire logic IO_RD_IN,
	input wire logic [7:0] IO_WDATA_IN,
	output logic [7:0] IO_RDATA_OUT,
	output logic IO_HIT_OUT,
	// status from timing and pixel pipelines
	input wire logic VRETRACE_IN,
	input wire logic DISPLAY_ACTIVE_IN,
	input wire logic [7:0] PIXEL_BITS_IN,
	input wire logic [3:0] SWITCH_SENSE_IN,
	input wire logic [3:0] PAL_INDEX_IN,
	// decoded configuration
	output vgar_misc_s MISC_CFG_OUT,
	output vgar_seq_s SEQ_CFG_OUT,
	output vgar_crt_s CRT_CFG_OUT,
	output vgar_gfx_s GFX_CFG_OUT,
	output logic [7:0] ATTR_MODE_OUT,
	output logic PAL_VIDEO_OUT,
	output logic [5:0] PAL_DATA_OUT,
	output logic VINT_OUT
);

	// writable bits of each sequencer register
	function automatic logic [7:0] seq_mask(input logic [7:0] idx);
		case (idx)
			8'h00: seq_mask = 8'h03;
			8'h01: seq_mask = 8'h3D;
			8'h02: seq_mask = 8'h0F;
			8'h03: seq_mask = 8'h3F;
			8'h04: seq_mask = 8'h0E;
			default: seq_mask = 8'h00;
		endcase
	endfunction

	// writable bits of each crt register
	function automatic logic [7:0] crt_mask(input logic [4:0] idx);
		case (idx)
			5'h08: crt_mask = 8'h7F;
			5'h0A: crt_mask = 8'h3F;
			5'h0B: crt_mask = 8'h7F;
			5'h14: crt_mask = 8'h7F;
			5'h17: crt_mask = 8'hEF;
			default: crt_mask = (idx < CRT_NUM) ? 8'hFF : 8'h00;
		endcase
	endfunction

	// writable bits of each graphics register
	function automatic logic [7:0] gfx_mask(input logic [4:0] idx);
		case (idx)
			5'h03: gfx_mask = 8'h1F;
			5'h04: gfx_mask = 8'h03;
			5'h05: gfx_mask = 8'h7B;
			5'h08: gfx_mask = 8'hFF;
			default: gfx_mask = (idx < GFX_NUM) ? 8'h0F : 8'h00;
		endcase
	endfunction

	// register state
	logic [7:0] misc_reg;
	logic [7:0] seq_idx_reg;
	logic [4:0] crt_idx_reg;
	logic [4:0] gfx_idx_reg;
	logic [5:0] attr_idx_reg;
	logic attr_flip_reg;
	logic [7:0] seq_reg [SEQ_NUM];
	logic [7:0] crt_reg [CRT_NUM];
	logic [7:0] gfx_reg [GFX_NUM];
	logic [5:0] pal_reg [PAL_NUM];
	logic [7:0] attr_mode_reg;
	logic [5:0] attr_plane_reg;
	logic vint_reg;
	logic vr_prev_reg;
	logic [7:0] rdata_reg;
	logic [5:0] pal_out_reg;

	// port decode; the crt ports follow the i/o select bit
	logic [15:0] crt_base;
	logic crt_blk;
	logic hit_crt_idx, hit_crt_dat, hit_stat1;
	logic hit_seq_idx, hit_seq_dat, hit_gfx_idx, hit_gfx_dat;
	logic hit_attr_w, hit_attr_r, hit_misc_w, hit_misc_r;
	assign crt_base = misc_reg[B_IOSEL] ? BASE_COLOR : BASE_MONO;
	assign crt_blk = IO_ADDR_IN[15:4] == crt_base[15:4];
	assign hit_crt_idx = crt_blk && IO_ADDR_IN[3:0] == OFS_CRT_IDX;
	assign hit_crt_dat = crt_blk && IO_ADDR_IN[3:0] == OFS_CRT_DAT;
	assign hit_stat1 = crt_blk && IO_ADDR_IN[3:0] == OFS_STAT1;
	assign hit_seq_idx = IO_ADDR_IN == PORT_SEQ_IDX;
	assign hit_seq_dat = IO_ADDR_IN == PORT_SEQ_DAT;
	assign hit_gfx_idx = IO_ADDR_IN == PORT_GFX_IDX;
	assign hit_gfx_dat = IO_ADDR_IN == PORT_GFX_DAT;
	assign hit_attr_w = IO_ADDR_IN == PORT_ATTR_W;
	assign hit_attr_r = IO_ADDR_IN == PORT_ATTR_R;
	assign hit_misc_w = IO_ADDR_IN == PORT_MISC_W;
	assign hit_misc_r = IO_ADDR_IN == PORT_MISC_R;
	assign IO_HIT_OUT = hit_crt_idx | hit_crt_dat | hit_stat1
		| hit_seq_idx | hit_seq_dat | hit_gfx_idx | hit_gfx_dat
		| hit_attr_w | hit_attr_r | hit_misc_w | hit_misc_r;

	// write strobes; protection only guards crt 00 through 07
	logic crt_prot;
	logic we_seq, we_crt, we_gfx, we_attr, we_pal, we_aidx;
	logic [4:0] aidx;
	assign crt_prot = crt_reg[CR_VRE][B_VRE_PROT]
		&& crt_idx_reg <= CR_PROT_LAST;
	assign we_seq = IO_WR_IN && hit_seq_dat && seq_idx_reg < SEQ_NUM;
	assign we_crt = IO_WR_IN && hit_crt_dat && crt_idx_reg < CRT_NUM
		&& !crt_prot;
	assign we_gfx = IO_WR_IN && hit_gfx_dat && gfx_idx_reg < GFX_NUM;
	assign we_attr = IO_WR_IN && hit_attr_w;
	assign we_aidx = we_attr && !attr_flip_reg;
	assign aidx = attr_idx_reg[4:0];
	// palette is closed to the host while the display owns it
	assign we_pal = we_attr && attr_flip_reg && aidx < PAL_NUM
		&& !attr_idx_reg[B_ATTR_SRC];

	// general output and index registers
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			misc_reg <= RST_VAL;
			seq_idx_reg <= RST_VAL;
			crt_idx_reg <= RST_VAL[4:0];
			gfx_idx_reg <= RST_VAL[4:0];
		end else begin
			if (IO_WR_IN && hit_misc_w)
				misc_reg <= IO_WDATA_IN & 8'hEF;
			if (IO_WR_IN && hit_seq_idx)
				seq_idx_reg <= IO_WDATA_IN;
			if (IO_WR_IN && hit_crt_idx)
				crt_idx_reg <= IO_WDATA_IN[4:0];
			if (IO_WR_IN && hit_gfx_idx)
				gfx_idx_reg <= IO_WDATA_IN[4:0];
		end
	end

	// sequencer bank; reserved bits never stored
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < SEQ_NUM; i++)
				seq_reg[i] <= RST_VAL;
		end else if (we_seq) begin
			seq_reg[seq_idx_reg[2:0]] <= IO_WDATA_IN
				& seq_mask(seq_idx_reg);
		end
	end

	// crt bank
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < CRT_NUM; i++)
				crt_reg[i] <= RST_VAL;
		end else if (we_crt) begin
			crt_reg[crt_idx_reg] <= IO_WDATA_IN & crt_mask(crt_idx_reg);
		end
	end

	// graphics bank
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < GFX_NUM; i++)
				gfx_reg[i] <= RST_VAL;
		end else if (we_gfx) begin
			gfx_reg[gfx_idx_reg[3:0]] <= IO_WDATA_IN
				& gfx_mask(gfx_idx_reg);
		end
	end

	// attribute flip-flop: status 1 read forces index state
	logic rd_stat1;
	assign rd_stat1 = IO_RD_IN && hit_stat1;
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN)
			attr_flip_reg <= 1'b0;
		else if (rd_stat1)
			attr_flip_reg <= 1'b0;
		else if (we_attr)
			attr_flip_reg <= !attr_flip_reg;
	end

	// attribute index, palette and mode registers
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			attr_idx_reg <= RST_VAL[5:0];
			attr_mode_reg <= RST_VAL;
			attr_plane_reg <= RST_VAL[5:0];
			for (int i = 0; i < PAL_NUM; i++)
				pal_reg[i] <= RST_VAL[5:0];
		end else begin
			if (we_aidx)
				attr_idx_reg <= IO_WDATA_IN[5:0];
			if (we_pal)
				pal_reg[aidx[3:0]] <= IO_WDATA_IN[5:0];
			if (we_attr && attr_flip_reg && aidx == AR_MODE)
				attr_mode_reg <= IO_WDATA_IN & 8'hEF;
			if (we_attr && attr_flip_reg && aidx == AR_PLANE)
				attr_plane_reg <= IO_WDATA_IN[5:0];
		end
	end

	// vertical interrupt: rising retrace edge sets, a write with the
	// clear bit low clears; a set in the same cycle wins
	logic vint_set, vint_clr;
	assign vint_set = VRETRACE_IN && !vr_prev_reg
		&& crt_reg[CR_VRE][B_VRE_EN];
	assign vint_clr = we_crt && crt_idx_reg == CR_VRE
		&& !IO_WDATA_IN[B_VRE_CLR];
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN) begin
			vint_reg <= 1'b0;
			vr_prev_reg <= 1'b0;
		end else begin
			vint_reg <= vint_set || (vint_reg && !vint_clr);
			vr_prev_reg <= VRETRACE_IN;
		end
	end
	assign VINT_OUT = vint_reg;

	// status bytes; the video mux picks one pixel-bit pair
	logic [1:0] vmux;
	logic [1:0] vsel;
	logic [7:0] stat0, stat1;
	assign vmux = attr_plane_reg[5:4];
	assign vsel = vmux == 2'b00 ? {PIXEL_BITS_IN[2], PIXEL_BITS_IN[0]}
		: vmux == 2'b01 ? {PIXEL_BITS_IN[5], PIXEL_BITS_IN[4]}
		: vmux == 2'b10 ? {PIXEL_BITS_IN[3], PIXEL_BITS_IN[1]}
		: {PIXEL_BITS_IN[7], PIXEL_BITS_IN[6]};
	assign stat0 = {vint_reg, 2'b00,
		SWITCH_SENSE_IN[misc_reg[3:2]], 4'h0};
	assign stat1 = {2'b00, vsel, VRETRACE_IN, 2'b00,
		!DISPLAY_ACTIVE_IN};

	// data port read values; out-of-range indices read zero
	logic [7:0] seq_rd, crt_rd, gfx_rd, attr_rd;
	assign seq_rd = seq_idx_reg < SEQ_NUM
		? seq_reg[seq_idx_reg[2:0]] : 8'h00;
	assign crt_rd = crt_idx_reg < CRT_NUM
		? crt_reg[crt_idx_reg] : 8'h00;
	assign gfx_rd = gfx_idx_reg < GFX_NUM
		? gfx_reg[gfx_idx_reg[3:0]] : 8'h00;
	assign attr_rd = aidx < PAL_NUM ? {2'b00, pal_reg[aidx[3:0]]}
		: aidx == AR_MODE ? attr_mode_reg
		: aidx == AR_PLANE ? {2'b00, attr_plane_reg}
		: 8'h00;

	// read multiplexer
	logic [7:0] rd_mux;
	assign rd_mux = hit_misc_r ? misc_reg
		: hit_misc_w ? stat0
		: hit_stat1 ? stat1
		: hit_seq_idx ? seq_idx_reg
		: hit_seq_dat ? seq_rd
		: hit_crt_idx ? {3'b000, crt_idx_reg}
		: hit_crt_dat ? crt_rd
		: hit_gfx_idx ? {3'b000, gfx_idx_reg}
		: hit_gfx_dat ? gfx_rd
		: hit_attr_w ? {2'b00, attr_idx_reg}
		: hit_attr_r ? attr_rd
		: 8'h00;

	// read data is held until the next read so slow hosts may sample late
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN)
			rdata_reg <= RST_VAL;
		else if (IO_RD_IN)
			rdata_reg <= rd_mux;
	end
	assign IO_RDATA_OUT = rdata_reg;

	// palette lookup for the display; zero while the host owns it
	always_ff @(posedge CLOCK_IN) begin
		if (!RESET_N_IN)
			pal_out_reg <= RST_VAL[5:0];
		else
			pal_out_reg <= attr_idx_reg[B_ATTR_SRC]
				? pal_reg[PAL_INDEX_IN] : 6'h00;
	end
	assign PAL_DATA_OUT = pal_out_reg;
	assign PAL_VIDEO_OUT = attr_idx_reg[B_ATTR_SRC];
	assign ATTR_MODE_OUT = attr_mode_reg;

	// general output fields
	assign MISC_CFG_OUT.color_io = misc_reg[B_IOSEL];
	assign MISC_CFG_OUT.vram_en = misc_reg[1];
	assign MISC_CFG_OUT.pclk_sel = vgar_pclk_e'(misc_reg[3:2]);
	assign MISC_CFG_OUT.page_odd = misc_reg[5];
	assign MISC_CFG_OUT.hsync_neg = misc_reg[6];
	assign MISC_CFG_OUT.vsync_neg = misc_reg[7];

	// sequencer fields
	assign SEQ_CFG_OUT.async_rst_n = seq_reg[0][0];
	assign SEQ_CFG_OUT.sync_rst_n = seq_reg[0][1];
	assign SEQ_CFG_OUT.dot8 = seq_reg[1][0];
	assign SEQ_CFG_OUT.shift_half = seq_reg[1][2];
	assign SEQ_CFG_OUT.dot_half = seq_reg[1][3];
	assign SEQ_CFG_OUT.shift_quarter = seq_reg[1][4];
	assign SEQ_CFG_OUT.screen_off = seq_reg[1][5];
	assign SEQ_CFG_OUT.plane_we = seq_reg[2][3:0];
	assign SEQ_CFG_OUT.font_sel = seq_reg[3][5:0];
	assign SEQ_CFG_OUT.mem_256k = seq_reg[4][1];
	assign SEQ_CFG_OUT.odd_even_n = seq_reg[4][2];
	assign SEQ_CFG_OUT.chain4 = seq_reg[4][3];

	// crt fields; the host's minus-5/minus-1 coding passes through as is
	logic [7:0] ovf, msl;
	assign ovf = crt_reg[7];
	assign msl = crt_reg[9];
	assign CRT_CFG_OUT.h_total = crt_reg[0];
	assign CRT_CFG_OUT.h_disp_end = crt_reg[1];
	assign CRT_CFG_OUT.h_blank_start = crt_reg[2];
	assign CRT_CFG_OUT.v_total = {ovf[5], ovf[0], crt_reg[6]};
	assign CRT_CFG_OUT.v_disp_end = {ovf[6], ovf[1], crt_reg[18]};
	assign CRT_CFG_OUT.v_sync_start = {ovf[7], ovf[2], crt_reg[16]};
	assign CRT_CFG_OUT.v_blank_start = {msl[5], ovf[3], crt_reg[21]};
	assign CRT_CFG_OUT.line_cmp = {msl[6], ovf[4], crt_reg[24]};
	assign CRT_CFG_OUT.start_addr = {crt_reg[12], crt_reg[13]};
	assign CRT_CFG_OUT.refresh5 = crt_reg[CR_VRE][6];
	assign CRT_CFG_OUT.row0_sub_n = crt_reg[23][0];
	assign CRT_CFG_OUT.row1_sub_n = crt_reg[23][1];
	assign CRT_CFG_OUT.wrap_256k = crt_reg[23][5];
	assign CRT_CFG_OUT.counters_run = crt_reg[23][7];

	// graphics fields and host memory window
	logic [1:0] win;
	assign win = gfx_reg[6][3:2];
	assign GFX_CFG_OUT.set_reset = gfx_reg[0][3:0];
	assign GFX_CFG_OUT.sr_enable = gfx_reg[1][3:0];
	assign GFX_CFG_OUT.cmp_value = gfx_reg[2][3:0];
	assign GFX_CFG_OUT.dont_care = gfx_reg[7][3:0];
	assign GFX_CFG_OUT.rotate = gfx_reg[3][2:0];
	assign GFX_CFG_OUT.func = gfx_reg[3][4:3];
	assign GFX_CFG_OUT.read_map = gfx_reg[4][1:0];
	assign GFX_CFG_OUT.write_mode = gfx_reg[5][1:0];
	assign GFX_CFG_OUT.read_cmp = gfx_reg[5][3];
	assign GFX_CFG_OUT.bit_mask = gfx_reg[8];
	assign GFX_CFG_OUT.win_base = win == 2'b10 ? 20'hB_0000
		: win == 2'b11 ? 20'hB_8000 : 20'hA_0000;
	assign GFX_CFG_OUT.win_top = win == 2'b01 ? 20'hA_FFFF
		: win == 2'b10 ? 20'hB_7FFF : 20'hB_FFFF;

endmodule

// >>> hw/vgar_pkg.sv
// Purpose: constants, types and field layouts of the standard register file
// Assumes: byte-wide host I/O cycles with a 16-bit port address
// Notes: all port addresses live here, with bank sizes and a few indices and bit positions
package vgar_pkg;

	// fixed host ports
	localparam logic [15:0] PORT_ATTR_W = 16'h03C0;
	localparam logic [15:0] PORT_ATTR_R = 16'h03C1;
	localparam logic [15:0] PORT_MISC_W = 16'h03C2;
	localparam logic [15:0] PORT_MISC_R = 16'h03CC;
	localparam logic [15:0] PORT_SEQ_IDX = 16'h03C4;
	localparam logic [15:0] PORT_SEQ_DAT = 16'h03C5;
	localparam logic [15:0] PORT_GFX_IDX = 16'h03CE;
	localparam logic [15:0] PORT_GFX_DAT = 16'h03CF;

	// relocatable ports: base plus low nibble
	localparam logic [15:0] BASE_MONO = 16'h03B0;
	localparam logic [15:0] BASE_COLOR = 16'h03D0;
	localparam logic [3:0] OFS_CRT_IDX = 4'h4;
	localparam logic [3:0] OFS_CRT_DAT = 4'h5;
	localparam logic [3:0] OFS_STAT1 = 4'hA;

	// bank sizes and indices
	localparam int SEQ_NUM = 5;
	localparam int CRT_NUM = 25;
	localparam int GFX_NUM = 9;
	localparam int PAL_NUM = 16;
	localparam logic [4:0] AR_MODE = 5'h10;
	localparam logic [4:0] AR_PLANE = 5'h12;
	localparam logic [4:0] CR_PROT_LAST = 5'h07;
	localparam logic [4:0] CR_VRE = 5'h11;

	// field positions
	localparam int B_IOSEL = 0;
	localparam int B_VRE_CLR = 4;
	localparam int B_VRE_EN = 5;
	localparam int B_VRE_PROT = 7;
	localparam int B_ATTR_SRC = 5;

	localparam logic [7:0] RST_VAL = 8'h00;

	// pixel clock source, coded as in the output register
	typedef enum logic [1:0] {
		PCLK_25, PCLK_28, PCLK_AUX, PCLK_45
	} vgar_pclk_e;

	typedef struct packed {
		logic color_io;
		logic vram_en;
		vgar_pclk_e pclk_sel;
		logic page_odd;
		logic hsync_neg;
		logic vsync_neg;
	} vgar_misc_s;

	typedef struct packed {
		logic async_rst_n;
		logic sync_rst_n;
		logic dot8;
		logic shift_half;
		logic dot_half;
		logic shift_quarter;
		logic screen_off;
		logic [3:0] plane_we;
		logic [5:0] font_sel;
		logic mem_256k;
		logic odd_even_n;
		logic chain4;
	} vgar_seq_s;

	typedef struct packed {
		logic [7:0] h_total;
		logic [7:0] h_disp_end;
		logic [7:0] h_blank_start;
		logic [9:0] v_total;
		logic [9:0] v_disp_end;
		logic [9:0] v_sync_start;
		logic [9:0] v_blank_start;
		logic [9:0] line_cmp;
		logic [15:0] start_addr;
		logic refresh5;
		logic row0_sub_n;
		logic row1_sub_n;
		logic wrap_256k;
		logic counters_run;
	} vgar_crt_s;

	typedef struct packed {
		logic [3:0] set_reset;
		logic [3:0] sr_enable;
		logic [3:0] cmp_value;
		logic [3:0] dont_care;
		logic [2:0] rotate;
		logic [1:0] func;
		logic [1:0] read_map;
		logic [1:0] write_mode;
		logic read_cmp;
		logic [7:0] bit_mask;
		logic [19:0] win_base;
		logic [19:0] win_top;
	} vgar_gfx_s;

endpackage

// >>> test/vgar_host.sv
// Purpose: host processor model issuing byte i/o cycles
// Assumes: one-cycle strobes, read byte valid just after the taking edge
// Notes: released address and data are inverted so stale values never help
`timescale 1ns/1ps

module vgar_host (
	// clock and read byte
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	// i/o cycle
	output logic [15:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out
);
	// idle bus from time zero
	initial begin
		addr_out = 16'hFFFF;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end

	// write: everything held through the edge that takes it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// read: the byte is picked up right after the taking edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		d = rdata_in;
		rd_out = 1'b0;
		addr_out = ~a;
	endtask
endmodule

// >>> test/vgar_regs_checker.sv
// Purpose: port-level checks of the standard register file
// Assumes: one clock, synchronous active low reset
// Notes: bound to every register file instance
`timescale 1ns/1ps

module vgar_regs_checker
	import vgar_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RESET_N_IN,
	// host cycle
	input wire logic [15:0] IO_ADDR_IN,
	input wire logic IO_WR_IN,
	input wire logic IO_RD_IN,
	input wire logic [7:0] IO_WDATA_IN,
	input wire logic [7:0] IO_RDATA_OUT,
	input wire logic IO_HIT_OUT,
	// status inputs and outputs
	input wire logic VRETRACE_IN,
	input wire logic DISPLAY_ACTIVE_IN,
	input wire vgar_misc_s MISC_CFG_OUT,
	input wire logic PAL_VIDEO_OUT,
	input wire logic [5:0] PAL_DATA_OUT,
	input wire logic VINT_OUT
);
	logic vr_q;
	logic vr_rise;
	logic [7:0] wd_q;
	logic [15:0] stat1_port;

	default clocking cb @(posedge CLOCK_IN);
	endclocking
	default disable iff (!RESET_N_IN);

	// one-cycle history; the interrupt may follow the edge by one clock
	always_ff @(posedge CLOCK_IN) begin
		vr_q <= VRETRACE_IN;
		wd_q <= IO_WDATA_IN;
	end
	assign vr_rise = VRETRACE_IN & ~vr_q;
	assign stat1_port = MISC_CFG_OUT.color_io ? 16'h03DA : 16'h03BA;

	// host cycles the checks start from
	sequence misc_wr;
		IO_WR_IN && IO_ADDR_IN == PORT_MISC_W;
	endsequence
	sequence stat0_rd;
		IO_RD_IN && IO_ADDR_IN == PORT_MISC_W;
	endsequence
	sequence stat1_rd;
		IO_RD_IN && IO_ADDR_IN == stat1_port;
	endsequence

	hit_color_a: assert property (
		IO_ADDR_IN == 16'h03D4 |-> IO_HIT_OUT == MISC_CFG_OUT.color_io)
		else $error("color base decode wrong");
	hit_mono_a: assert property (
		IO_ADDR_IN == 16'h03B4 |-> IO_HIT_OUT == !MISC_CFG_OUT.color_io)
		else $error("mono base decode wrong");
	misc_field_a: assert property (misc_wr |=>
		{MISC_CFG_OUT.vsync_neg, MISC_CFG_OUT.hsync_neg} == wd_q[7:6])
		else $error("sync polarity not taken from write");
	stat0_vint_a: assert property (
		stat0_rd |=> IO_RDATA_OUT[7] == $past(VINT_OUT))
		else $error("status 0 interrupt bit wrong");
	stat1_live_a: assert property (stat1_rd |=>
		IO_RDATA_OUT[3] == vr_q && IO_RDATA_OUT[0] == !$past(DISPLAY_ACTIVE_IN))
		else $error("status 1 live bits wrong");
	unmapped_zero_a: assert property (
		IO_RD_IN && !IO_HIT_OUT |=> IO_RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (
		!IO_RD_IN |=> $stable(IO_RDATA_OUT))
		else $error("read byte changed without a read");
	vint_cause_a: assert property (
		$rose(VINT_OUT) |-> vr_rise || $past(vr_rise))
		else $error("interrupt rose without retrace edge");
	vint_hold_a: assert property (
		VINT_OUT && !IO_WR_IN |=> VINT_OUT)
		else $error("interrupt dropped without a write");
	pal_owner_a: assert property ($changed(PAL_VIDEO_OUT) |->
		$past(IO_WR_IN) && $past(IO_ADDR_IN) == PORT_ATTR_W)
		else $error("palette owner changed without attribute write");
	pal_blank_a: assert property (
		!PAL_VIDEO_OUT [*2] |-> PAL_DATA_OUT == 6'h00)
		else $error("palette data shown while host owns it");
endmodule

bind vgar_regs vgar_regs_checker chk (.CLOCK_IN(CLOCK_IN),
	.RESET_N_IN(RESET_N_IN), .IO_ADDR_IN(IO_ADDR_IN), .IO_WR_IN(IO_WR_IN),
	.IO_RD_IN(IO_RD_IN), .IO_WDATA_IN(IO_WDATA_IN),
	.IO_RDATA_OUT(IO_RDATA_OUT), .IO_HIT_OUT(IO_HIT_OUT),
	.VRETRACE_IN(VRETRACE_IN), .DISPLAY_ACTIVE_IN(DISPLAY_ACTIVE_IN),
	.MISC_CFG_OUT(MISC_CFG_OUT), .PAL_VIDEO_OUT(PAL_VIDEO_OUT),
	.PAL_DATA_OUT(PAL_DATA_OUT), .VINT_OUT(VINT_OUT));

// >>> test/vgar_regs_bench.sv
// Purpose: self-checking bench of the standard register file
// Assumes: host model spaces cycles one clock apart
// Notes: expected bytes come from a small model kept beside the design
`timescale 1ns/1ps

module vgar_regs_bench
	import vgar_pkg::*;
;
	logic clk, rst_n, wr, rd, hit, vr, da, pvid, vint;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, pix, amode, r, o, m, v;
	logic [3:0] sw, pidx;
	logic [5:0] pdata;
	vgar_misc_s misc;
	vgar_seq_s seq_c;
	vgar_crt_s crt_c;
	vgar_gfx_s gfx_c;
	int seed = 23982;
	int errors = 0;
	int n_tests = 0;
	int misc_m, sidx, cidx, gidx;
	int seq_m[5], crt_m[25], gfx_m[9];
	int pal_m[$];
	int seq_k[5] = '{8'h03, 8'h3D, 8'h0F, 8'h3F, 8'h0E};
	logic [19:0] wb[4] = '{20'hA_0000, 20'hA_0000, 20'hB_0000, 20'hB_8000};
	logic [19:0] wt[4] = '{20'hB_FFFF, 20'hA_FFFF, 20'hB_7FFF, 20'hB_FFFF};
	int pair_hi[4] = '{2, 5, 3, 7};
	int pair_lo[4] = '{0, 4, 1, 6};
	logic [15:0] crt = 16'h03D4;

	vgar_regs dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .IO_ADDR_IN(addr),
		.IO_WR_IN(wr), .IO_RD_IN(rd), .IO_WDATA_IN(wdata),
		.IO_RDATA_OUT(rdata), .IO_HIT_OUT(hit), .VRETRACE_IN(vr),
		.DISPLAY_ACTIVE_IN(da), .PIXEL_BITS_IN(pix), .SWITCH_SENSE_IN(sw),
		.PAL_INDEX_IN(pidx), .MISC_CFG_OUT(misc), .SEQ_CFG_OUT(seq_c),
		.CRT_CFG_OUT(crt_c), .GFX_CFG_OUT(gfx_c), .ATTR_MODE_OUT(amode),
		.PAL_VIDEO_OUT(pvid), .PAL_DATA_OUT(pdata), .VINT_OUT(vint));
	vgar_host host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
		.wr_out(wr), .rd_out(rd), .wdata_out(wdata));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic int crt_k(int i);
		return (i == 8 || i == 11 || i == 20) ? 8'h7F : (i == 10) ? 8'h3F :
			(i == 23) ? 8'hEF : 8'hFF;
	endfunction

	function automatic int gfx_k(int i);
		return (i == 3) ? 8'h1F : (i == 4) ? 8'h03 : (i == 5) ? 8'h7B :
			(i == 8) ? 8'hFF : 8'h0F;
	endfunction

	// write through the host and mirror it in the model
	task automatic put(input logic [15:0] a, input logic [7:0] d);
		int b;
		b = misc_m[0] ? 16'h03D0 : 16'h03B0;
		host.wr(a, d);
		if (a == PORT_MISC_W) misc_m = d & 8'hEF;
		if (a == PORT_SEQ_IDX) sidx = d;
		if (a == PORT_SEQ_DAT && sidx < 5) seq_m[sidx] = d & seq_k[sidx];
		if (a == PORT_GFX_IDX) gidx = d & 31;
		if (a == PORT_GFX_DAT && gidx < 9) gfx_m[gidx] = d & gfx_k(gidx);
		if (a == b + 4) cidx = d & 31;
		if (a == b + 5 && cidx < 25 && !(cidx < 8 && crt_m[17][7]))
			crt_m[cidx] = d & crt_k(cidx);
	endtask

	task automatic ix(input logic [15:0] p, input logic [7:0] i,
		input logic [7:0] d);
		put(p, i);
		put(p + 16'h0001, d);
	endtask

	task automatic get(input logic [15:0] a, input logic [7:0] e);
		host.rd(a, v);
		check(v, e);
	endtask

	initial begin
		rst_n = 1'b0;
		vr = 1'b0;
		da = 1'b1;
		pix = 8'h00;
		sw = 4'h0;
		pidx = 4'h0;
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check(misc, 0);
		get(16'h03B5, 8'h00);
		// every clock source with its switch sense
		for (int k = 0; k < 4; k++) begin
			r = 8'(($random(seed) & 8'hF2) | (k << 2));
			sw = 4'($random(seed));
			put(PORT_MISC_W, r);
			check(misc.pclk_sel, k);
			check({misc.vsync_neg, misc.hsync_neg}, r[7:6]);
			get(PORT_MISC_R, misc_m);
			get(PORT_MISC_W, {3'b000, sw[k], 4'h0});
		end
		// crt ports move with the base select bit
		ix(16'h03B4, 8'h13, 8'h5A);
		get(16'h03D5, 8'h00);
		put(PORT_MISC_W, 8'h01);
		get(16'h03D5, crt_m[19]);
		get(16'h03B4, 8'h00);
		// sequencer bank, one index past the end included
		for (int i = 0; i < 6; i++) begin
			ix(PORT_SEQ_IDX, 8'(i), 8'($random(seed)));
			get(PORT_SEQ_DAT, i < 5 ? seq_m[i] : 0);
		end
		check({seq_c.sync_rst_n, seq_c.async_rst_n}, seq_m[0][1:0]);
		check({seq_c.screen_off, seq_c.shift_quarter, seq_c.dot_half,
			seq_c.shift_half, seq_c.dot8}, {seq_m[1][5:2], seq_m[1][0]});
		check(seq_c.plane_we, seq_m[2][3:0]);
		check({seq_c.chain4, seq_c.odd_even_n, seq_c.mem_256k},
			seq_m[4][3:1]);
		// 100 characters, 525 lines, 480 shown, blank start 479; other high bits random
		o = 8'(($random(seed) & 8'h94) | 8'h2A);
		m = 8'($random(seed) & 8'hDF);
		ix(crt, 8'h07, o);
		ix(crt, 8'h09, m);
		ix(crt, 8'h00, 100 - 5);
		ix(crt, 8'h01, 100 - 1);
		ix(crt, 8'h06, 8'h0B);
		ix(crt, 8'h12, 8'hDF);
		ix(crt, 8'h15, 8'hDF);
		ix(crt, 8'h10, 8'hEA);
		ix(crt, 8'h18, 8'hFF);
		check(crt_c.h_total, 95);
		check(crt_c.h_disp_end, 99);
		check(crt_c.v_total, {o[5], o[0], 8'h0B});
		check(crt_c.v_disp_end, {o[6], o[1], 8'hDF});
		check(crt_c.v_sync_start, {o[7], o[2], 8'hEA});
		check(crt_c.v_blank_start, {m[5], o[3], 8'hDF});
		check(crt_c.line_cmp, {m[6], o[4], 8'hFF});
		check(crt_c.v_total, 525 - 2);
		check(crt_c.v_disp_end, 480 - 1);
		// protection freezes the first eight, the overflow too
		ix(crt, 8'h11, 8'hC0);
		check(crt_c.refresh5, 1);
		ix(crt, 8'h00, 8'h12);
		ix(crt, 8'h07, ~o);
		check(crt_c.h_total, 95);
		get(16'h03D5, crt_m[7]);
		ix(crt, 8'h08, o);
		get(16'h03D5, crt_m[8]);
		ix(crt, 8'h11, 8'h30);
		check(crt_c.refresh5, 0);
		r = 8'($random(seed));
		ix(crt, 8'h17, r);
		check({crt_c.counters_run, crt_c.wrap_256k}, {r[7], r[5]});
		check({crt_c.row1_sub_n, crt_c.row0_sub_n}, r[1:0]);
		// retrace edge raises the interrupt, bit 4 low clears it
		vr = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(vint, 1);
		get(PORT_MISC_W, {1'b1, 2'b00, sw[0], 4'h0});
		get(16'h03DA, {4'h0, vr, 2'b00, ~da});
		ix(crt, 8'h11, 8'h20);
		check(vint, 0);
		vr = 1'b0;
		ix(crt, 8'h11, 8'h10);
		vr = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check(vint, 0);
		vr = 1'b0;
		// latch function, write mode and window, all codes; read type random
		for (int k = 0; k < 4; k++) begin
			r = 8'($random(seed));
			ix(PORT_GFX_IDX, 8'h03, {3'b000, k[1:0], r[2:0]});
			check(gfx_c.func, k);
			check(gfx_c.rotate, r[2:0]);
			ix(PORT_GFX_IDX, 8'h05, {4'h0, r[3], 1'b0, k[1:0]});
			check(gfx_c.write_mode, k);
			check(gfx_c.read_cmp, r[3]);
			ix(PORT_GFX_IDX, 8'h06, {4'h0, k[1:0], r[1:0]});
			check(gfx_c.win_base, wb[k]);
			check(gfx_c.win_top, wt[k]);
			get(PORT_GFX_DAT, gfx_m[6]);
		end
		ix(PORT_GFX_IDX, 8'h09, 8'hFF);
		get(PORT_GFX_DAT, 8'h00);
		// attribute pairs; a status read restarts at the index
		get(16'h03DA, {4'h0, vr, 2'b00, ~da});
		r = 8'($random(seed));
		pal_m.push_back(r & 8'h3F);
		put(PORT_ATTR_W, 8'h03);
		put(PORT_ATTR_W, r);
		get(PORT_ATTR_R, pal_m[0]);
		// every video status mux code picks its own pixel-bit pair
		pix = 8'($random(seed));
		for (int k = 0; k < 4; k++) begin
			put(PORT_ATTR_W, 8'h12);
			put(PORT_ATTR_W, 8'(k << 4));
			get(16'h03DA, {2'b00, pix[pair_hi[k]], pix[pair_lo[k]],
				vr, 2'b00, ~da});
		end
		put(PORT_ATTR_W, 8'h23);
		put(PORT_ATTR_W, 8'h15);
		pidx = 4'h3;
		pix = 8'($random(seed));
		da = 1'b0;
		check(pvid, 1);
		get(16'h03DA, {2'b00, pix[7:6], vr, 2'b00, ~da});
		check(pdata, pal_m[0]);
		put(PORT_ATTR_W, 8'h10);
		put(PORT_ATTR_W, r);
		check(amode, r & 8'hEF);
		put(PORT_ATTR_W, 8'h03);
		check(pvid, 0);
		// a status read mid-pair sends the next write back to the index
		get(16'h03DA, {2'b00, pix[7:6], vr, 2'b00, ~da});
		put(PORT_ATTR_W, 8'h03);
		pal_m.push_back(8'h15);
		put(PORT_ATTR_W, 8'h15);
		check(pdata, 0);
		get(PORT_ATTR_R, pal_m[1]);
		get(16'h03C3, 8'h00);
		complete_run();
	end
endmodule
